// ==== hdl/srs_pkg.sv ====
package srs_pkg;
  localparam int BitOverflow = 0;
  localparam int BitOverload = 1;
  localparam int BitSweepDone = 2;
  localparam int BitReadingDone = 3;
  localparam int BitReady = 4;
  localparam int BitError = 5;
  localparam int BitRqs = 6;
  localparam int BitOutputDone = 7;
  localparam logic [7:0] MaskReset = 8'h00;
  localparam logic [7:0] StatusReset = 8'h00;
  localparam logic [7:0] MaskValid = 8'hbf;
  localparam int CountWidth = 16;
  localparam logic [15:0] CountReset = 16'h0001;
  localparam logic [1:0] WaveDc = 2'h0;
  localparam logic [1:0] WavePulse = 2'h1;
  localparam logic [1:0] WaveStair = 2'h2;
  localparam logic [1:0] WaveExt = 2'h3;
endpackage : srs_pkg

// ==== hdl/srs_sweep_counter.sv ====
`timescale 1ns/1ps
module srs_sweep_counter #(
  parameter int Width = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic sweepStart,
  input wire logic readingTaken,
  input wire logic [1:0] waveform,
  input wire logic [Width-1:0] countParam,
  input wire logic [Width-1:0] biasFirst,
  input wire logic [Width-1:0] biasLast,
  input wire logic [Width-1:0] biasStep,
  output logic sweeping,
  output logic sweepDone
);
  logic [Width-1:0] target_reg;
  logic [Width-1:0] taken_reg;
  logic [Width-1:0] span;
  logic [Width-1:0] stepNz;
  logic [Width-1:0] targetNext;

  // staircase/pulse length derives from bias sweep span; dc/ext from count
  always_comb begin
    span = (biasLast >= biasFirst) ? biasLast - biasFirst : biasFirst - biasLast;
    stepNz = (biasStep == '0) ? Width'(1) : biasStep;
    if (waveform == srs_pkg::WavePulse || waveform == srs_pkg::WaveStair) begin
      targetNext = Width'(span / stepNz) + Width'(1);
    end else begin
      targetNext = (countParam == '0) ? Width'(1) : countParam;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sweeping <= 1'b0;
      sweepDone <= 1'b0;
      taken_reg <= '0;
      target_reg <= '0;
    end else begin
      sweepDone <= 1'b0;
      if (clear) begin
        sweeping <= 1'b0;
        taken_reg <= '0;
      end else if (sweepStart) begin
        sweeping <= 1'b1;
        taken_reg <= '0;
        target_reg <= targetNext;
      end else if (sweeping && readingTaken) begin
        taken_reg <= taken_reg + Width'(1);
        if (taken_reg + Width'(1) >= target_reg) begin
          sweeping <= 1'b0;
          sweepDone <= 1'b1;
        end
      end
    end
  end
endmodule : srs_sweep_counter

// ==== hdl/srs_service_request.sv ====
`timescale 1ns/1ps
module srs_service_request #(
  parameter int CountWidth = srs_pkg::CountWidth
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic deviceClear,
  input wire logic maskWrite,
  input wire logic [7:0] maskValue,
  input wire logic readingOverRange,
  input wire logic readingInRange,
  input wire logic readingRequest,
  input wire logic inputOverload,
  input wire logic sweepStart,
  input wire logic readingTaken,
  input wire logic [1:0] waveform,
  input wire logic [CountWidth-1:0] countParam,
  input wire logic [CountWidth-1:0] biasFirst,
  input wire logic [CountWidth-1:0] biasLast,
  input wire logic [CountWidth-1:0] biasStep,
  input wire logic readingReady,
  input wire logic commandBusy,
  input wire logic errorEvent,
  input wire logic errorWordRead,
  input wire logic outputStart,
  input wire logic outputEnd,
  input wire logic serialPoll,
  output logic srqOut,
  output logic srqOe,
  output logic [7:0] serviceStatusByte
);
  // ************************************************************
  // pin synchroniser
  // ************************************************************
  // overload is a level from the analog front end, not our clock
  logic overloadMeta_reg;
  logic overloadSync_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overloadMeta_reg <= 1'b0;
      overloadSync_reg <= 1'b0;
    end else begin
      overloadMeta_reg <= inputOverload;
      overloadSync_reg <= overloadMeta_reg;
    end
  end

  // ************************************************************
  // mask register
  // ************************************************************
  logic [7:0] enableMask_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enableMask_reg <= srs_pkg::MaskReset;
    end else if (deviceClear) begin
      enableMask_reg <= srs_pkg::MaskReset;
    end else if (maskWrite) begin
      // argument is a sum of weights; bit six has no event so is dropped
      enableMask_reg <= maskValue & srs_pkg::MaskValid;
    end
  end

  // ************************************************************
  // sweep length tracking
  // ************************************************************
  logic sweeping;
  logic sweepDonePulse;

  srs_sweep_counter #(
    .Width(CountWidth)
  ) u_sweep (
    .clk(clk),
    .rst(rst),
    .clear(deviceClear),
    .sweepStart(sweepStart),
    .readingTaken(readingTaken),
    .waveform(waveform),
    .countParam(countParam),
    .biasFirst(biasFirst),
    .biasLast(biasLast),
    .biasStep(biasStep),
    .sweeping(sweeping),
    .sweepDone(sweepDonePulse)
  );

  // ************************************************************
  // live event flags
  // ************************************************************
  // set beats a flag's own clear where both land in the same cycle; deviceClear beats every set
  logic [7:0] live_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      live_reg <= srs_pkg::StatusReset;
    end else if (deviceClear) begin
      live_reg <= srs_pkg::StatusReset;
    end else begin
      if (readingOverRange) begin
        live_reg[srs_pkg::BitOverflow] <= 1'b1;
      end else if (readingInRange || readingRequest) begin
        live_reg[srs_pkg::BitOverflow] <= 1'b0;
      end
      live_reg[srs_pkg::BitOverload] <= overloadSync_reg;
      if (sweepDonePulse) begin
        live_reg[srs_pkg::BitSweepDone] <= 1'b1;
      end else if (sweepStart || sweeping) begin
        live_reg[srs_pkg::BitSweepDone] <= 1'b0;
      end
      if (readingReady) begin
        live_reg[srs_pkg::BitReadingDone] <= 1'b1;
      end else if (readingRequest) begin
        live_reg[srs_pkg::BitReadingDone] <= 1'b0;
      end
      live_reg[srs_pkg::BitReady] <= ~commandBusy;
      if (errorEvent) begin
        live_reg[srs_pkg::BitError] <= 1'b1;
      end else if (errorWordRead) begin
        live_reg[srs_pkg::BitError] <= 1'b0;
      end
      live_reg[srs_pkg::BitRqs] <= 1'b0;
      if (outputEnd) begin
        live_reg[srs_pkg::BitOutputDone] <= 1'b1;
      end else if (outputStart) begin
        live_reg[srs_pkg::BitOutputDone] <= 1'b0;
      end
    end
  end

  // ************************************************************
  // request and latched status byte
  // ************************************************************
  // a flag must be enabled and present while the byte is not frozen to raise service
  logic requestCause;
  logic requesting_reg;
  logic frozen_reg;
  logic [7:0] latched_reg;

  assign requestCause = |(live_reg & enableMask_reg & srs_pkg::MaskValid);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      requesting_reg <= 1'b0;
    end else if (deviceClear || serialPoll) begin
      requesting_reg <= 1'b0;
    end else if (requestCause && !frozen_reg) begin
      requesting_reg <= 1'b1;
    end
  end

  // while frozen no new request is raised; the byte holds its snapshot except the rqs bit, which follows requesting_reg
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frozen_reg <= 1'b0;
      latched_reg <= srs_pkg::StatusReset;
    end else if (deviceClear) begin
      frozen_reg <= 1'b0;
      latched_reg <= srs_pkg::StatusReset;
    end else if (errorWordRead) begin
      frozen_reg <= 1'b0;
    end else if (requestCause && !frozen_reg && !requesting_reg) begin
      frozen_reg <= 1'b1;
      latched_reg <= live_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serviceStatusByte <= srs_pkg::StatusReset;
      srqOut <= 1'b0;
      srqOe <= 1'b0;
    end else begin
      serviceStatusByte <= frozen_reg ? latched_reg : live_reg;
      serviceStatusByte[srs_pkg::BitRqs] <= requesting_reg;
      // open-drain: pull low while requesting
      srqOut <= 1'b0;
      srqOe <= requesting_reg && !serialPoll && !deviceClear;
    end
  end
endmodule : srs_service_request

// ==== verif/srs_assertions.sv ====
`timescale 1ns/1ps
module srs_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic deviceClear,
  input wire logic maskWrite,
  input wire logic [7:0] maskValue,
  input wire logic errorEvent,
  input wire logic errorWordRead,
  input wire logic serialPoll,
  input wire logic srqOut,
  input wire logic srqOe,
  input wire logic [7:0] serviceStatusByte
);
  // ****
  // request line checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] maskReg;
  logic [2:0] zeroCnt;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskReg <= 8'h00;
    end else if (deviceClear) begin
      maskReg <= 8'h00;
    end else if (maskWrite) begin
      maskReg <= maskValue;
    end
  end
  // the counter lets in-flight requests drain before a zero mask is trusted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zeroCnt <= 3'h0;
    end else if (maskReg != 8'h00) begin
      zeroCnt <= 3'h0;
    end else if (zeroCnt != 3'h7) begin
      zeroCnt <= zeroCnt + 3'h1;
    end
  end
  property p_line_low; srqOut == 1'b0; endproperty
  a_line_low: assert property (p_line_low) else $error("srq pin level wrong");
  property p_rqs_rise; $rose(srqOe) |-> serviceStatusByte[6]; endproperty
  a_rqs_rise: assert property (p_rqs_rise) else $error("rqs not set");
  property p_rqs_clear; !srqOe && !$past(srqOe) |-> !serviceStatusByte[6]; endproperty
  a_rqs_clear: assert property (p_rqs_clear) else $error("rqs set idle");
  property p_poll; serialPoll && srqOe && !errorWordRead |=> !srqOe ##1 !serviceStatusByte[6];
  endproperty
  a_poll: assert property (p_poll) else $error("poll kept request");
  property p_dcl; deviceClear |=> !srqOe; endproperty
  a_dcl: assert property (p_dcl) else $error("clear kept request");
  property p_err; errorEvent && maskReg[5] && serviceStatusByte == 8'h00 && !srqOe |-> ##3 srqOe;
  endproperty
  a_err: assert property (p_err) else $error("enabled error no request");
  property p_zero; zeroCnt == 3'h7 && !srqOe |=> !srqOe; endproperty
  a_zero: assert property (p_zero) else $error("request with zero mask");
  property p_freeze;
    srqOe && $past(srqOe) && !$past(errorWordRead) && !$past(errorWordRead, 2) |->
      $stable(serviceStatusByte[5:0]) && $stable(serviceStatusByte[7]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("byte moved while frozen");
  c_rise: cover property ($rose(srqOe));
  c_poll: cover property (serialPoll && srqOe);
  c_dcl: cover property (deviceClear && srqOe);
endmodule : srs_assertions

// ==== verif/srs_poll_ctrl.sv ====
`timescale 1ns/1ps
module srs_poll_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic [3:0] delay,
  input wire logic srqOe,
  input wire logic [7:0] statusByte,
  output logic serialPoll,
  output logic [7:0] polledByte
);
  // ****
  // serial poll controller
  // ****
  logic [3:0] waitCnt;
  // delay models a slow controller; the byte is taken at the poll
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitCnt <= 4'h0;
      serialPoll <= 1'b0;
      polledByte <= 8'h00;
    end else begin
      serialPoll <= 1'b0;
      if (!enable || !srqOe || serialPoll) waitCnt <= 4'h0;
      else if (waitCnt != delay) waitCnt <= waitCnt + 4'h1;
      else begin
        serialPoll <= 1'b1;
        polledByte <= statusByte;
      end
    end
  end
endmodule : srs_poll_ctrl

// ==== verif/tb.sv ====
`timescale 1ns/1ps
module tb;
  // ****
  // stimulus and checks
  // ****
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] ev = 12'h000;
  logic [7:0] maskValue = 8'h00;
  logic inputOverload = 1'b0;
  logic commandBusy = 1'b1;
  logic [1:0] waveform = 2'h0;
  logic pollEn = 1'b0;
  logic [3:0] pollDelay = 4'h0;
  logic serialPoll, srqOut, srqOe;
  logic [7:0] serviceStatusByte, polledByte;
  int failures = 0;
  int samples_checked = 0;
  int tbl [4][3] = '{'{0, 2, 3}, '{3, 7, 4}, '{5, 8, 9}, '{7, 11, 10}};
  initial forever #20 clk = ~clk;
  srs_service_request i_srs_service_request (.clk, .rst, .deviceClear(ev[0]), .maskWrite(ev[1]),
    .maskValue, .readingOverRange(ev[2]), .readingInRange(ev[3]), .readingRequest(ev[4]),
    .inputOverload, .sweepStart(ev[5]), .readingTaken(ev[6]), .waveform,
    .countParam(16'h0003), .biasFirst(16'h0001), .biasLast(16'h0005), .biasStep(16'h0002),
    .readingReady(ev[7]), .commandBusy, .errorEvent(ev[8]), .errorWordRead(ev[9]),
    .outputStart(ev[10]), .outputEnd(ev[11]), .serialPoll, .srqOut, .srqOe, .serviceStatusByte);
  srs_poll_ctrl i_srs_poll_ctrl (.clk, .rst, .enable(pollEn), .delay(pollDelay), .srqOe,
    .statusByte(serviceStatusByte), .serialPoll, .polledByte);
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic strobe(int idx);
    @(posedge clk) ev <= 12'h001 << idx;
    @(posedge clk) ev <= 12'h000;
  endtask : strobe
  task automatic setMask(logic [7:0] v);
    @(posedge clk) maskValue <= v;
    strobe(1);
  endtask : setMask
  task automatic settle(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic waitSrq(logic exp);
    for (int i = 0; i < 20 && srqOe !== exp; i++) settle(1);
    chk("srqOe", {7'h00, exp}, {7'h00, srqOe});
    chk("srqOut", 8'h00, {7'h00, srqOut});
  endtask : waitSrq
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    settle(1);
    chk("reset byte", 8'h00, serviceStatusByte);
    for (int m = 0; m < 2; m++) begin
      for (int t = 0; t < 4; t++) begin
        setMask(m ? ((8'h01 << tbl[t][0]) | 8'h04) : 8'h00);
        pollDelay <= 4'(tbl[t][0]);
        pollEn <= 1'b1;
        strobe(tbl[t][1]);
        settle(3);
        chk("status byte", (8'h01 << tbl[t][0]) | (m ? 8'h40 : 8'h00), serviceStatusByte);
        waitSrq(m[0]);
        if (m) begin
          waitSrq(1'b0);
          chk("polled byte", (8'h01 << tbl[t][0]) | 8'h40, polledByte);
          strobe(8);
          settle(3);
          chk("frozen byte", 8'h01 << tbl[t][0], serviceStatusByte);
        end
        strobe(tbl[t][2]);
        strobe(9);
        settle(3);
        chk("cleared byte", 8'h00, serviceStatusByte);
      end
    end
    @(posedge clk) inputOverload <= 1'b1;
    commandBusy <= 1'b0;
    settle(6);
    chk("level flags", 8'h12, serviceStatusByte);
    @(posedge clk) inputOverload <= 1'b0;
    commandBusy <= 1'b1;
    settle(6);
    chk("level flags", 8'h00, serviceStatusByte);
    setMask(8'h20);
    pollEn <= 1'b0;
    strobe(8);
    waitSrq(1'b1);
    strobe(0);
    settle(1);
    chk("clear srq", 8'h00, {7'h00, srqOe});
    strobe(8);
    settle(6);
    chk("clear mask", 8'h20, serviceStatusByte);
    strobe(9);
    for (int w = 0; w < 4; w++) begin
      @(posedge clk) waveform <= w[1:0];
      strobe(5);
      settle(3);
      chk("sweeping", 8'h00, serviceStatusByte);
      repeat (2) strobe(6);
      settle(6);
      chk("sweep short", 8'h00, serviceStatusByte);
      strobe(6);
      settle(6);
      chk("sweep done", 8'h04, serviceStatusByte);
    end
    test_done;
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done;
  end
endmodule : tb
bind srs_service_request srs_assertions i_srs_assertions (.clk, .rst, .deviceClear, .maskWrite,
  .maskValue, .errorEvent, .errorWordRead, .serialPoll, .srqOut, .srqOe, .serviceStatusByte);
